// ==== core/iap_flash_control_regs.sv ====
// Flash programming control, address, data and reset key registers
// How it works
// - Unlock trigger self-clears when window timer expires
// - Write start runs write, clears when done
// - Reads blocked unless read enable set
// - Read start runs read, clears when done
// - Core halted while an operation runs
// - Writing 55h to reset key resets chip
// - Buffer clear bit self-clears after clearing
// - Buffer clear upper seven bits read zero
// - Address high holds bits to 13
// - Word0 low write only stores the byte
// - Word0 high write loads 16-bit word
// - Address increments after each buffer load
// - Four readable writable 16-bit data words
// - Operation select codes write/erase/read/unlock
// - Program enable set only by hardware
// - Exact six-byte key enables programming
// - Address stops at page last word
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iap_flash_control_regs
	import iap_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Flash array side
	output flash_req_s flash_req,
	input wire logic flash_done,
	input wire logic [15:0] flash_rdata,
	output buf_load_s buf_load,
	output logic buf_clear,
	// System side
	output logic core_halt,
	output logic chip_reset
);
	// Main control fields
	logic program_enabled;
	logic [2:0] operation_select;
	logic unlock_trigger;
	logic write_start;
	logic read_enable_ctl;
	logic read_start;
	// Other registers
	logic [7:0] chip_reset_key;
	logic buffer_clear_start;
	logic [ADDR_W-1:0] flash_address_bits;
	logic [7:0] word_low [4];
	logic [7:0] word_high [4];
	// Timers and operation sequencer
	logic [7:0] unlock_timer;
	logic [7:0] clear_timer;
	op_state_e op_state;
	op_state_e next_op_state;
	logic [2:0] active_op;

	// Write decode per register
	wire wr_main = reg_write && (reg_addr == REG_MAIN_CONTROL);
	wire wr_key = reg_write && (reg_addr == REG_RESET_KEY);
	wire wr_clear = reg_write && (reg_addr == REG_BUF_CLEAR);
	wire wr_alow = reg_write && (reg_addr == REG_ADDR_LOW);
	wire wr_ahigh = reg_write && (reg_addr == REG_ADDR_HIGH);
	wire wr_w0high = reg_write && (reg_addr == REG_WORD0_HIGH);
	// Data word index: low/high pairs start at word0 low
	wire [3:0] data_off = reg_addr - REG_WORD0_LOW;
	wire in_data = (reg_addr >= REG_WORD0_LOW) && (reg_addr <= REG_WORD3_HIGH);
	wire [1:0] data_idx = data_off[2:1];
	wire data_is_high = data_off[0];

	// Exact key pattern in words 1..3
	wire key_ok = (word_low[1] == KEY_W1_LOW) && (word_high[1] == KEY_W1_HIGH) &&
		(word_low[2] == KEY_W2_LOW) && (word_high[2] == KEY_W2_HIGH) &&
		(word_low[3] == KEY_W3_LOW) && (word_high[3] == KEY_W3_HIGH);

	// Start request decode from a main control write
	wire sw_write = wr_main && reg_wdata[BIT_WRITE_START];
	wire sw_read = wr_main && reg_wdata[BIT_READ_START];
	wire [2:0] wr_opsel = reg_wdata[OPSEL_LSB+2:OPSEL_LSB];
	// Erase/write need unlock; read needs read enable
	wire start_ok_write = sw_write && program_enabled &&
		((wr_opsel == OP_WRITE) || (wr_opsel == OP_ERASE));
	wire start_ok_read = sw_read && reg_wdata[BIT_READ_ENABLE] &&
		(wr_opsel == OP_READ);
	wire launch = (op_state == ST_IDLE) && (start_ok_write || start_ok_read);

	// Page-bounded increment of the address
	function automatic logic [ADDR_W-1:0] bump_addr(input logic [ADDR_W-1:0] a);
		if (a[PAGE_BITS-1:0] == PAGE_LAST) begin
			bump_addr = a;
		end else begin
			bump_addr = a + ADDR_ONE;
		end
	endfunction

	// Main control write, hardware clears and sets
	always_ff @(posedge clk) begin
		if (rst) begin
			program_enabled <= 1'b0;
			operation_select <= OP_WRITE;
			unlock_trigger <= 1'b0;
			write_start <= 1'b0;
			read_enable_ctl <= 1'b0;
			read_start <= 1'b0;
		end else begin
			// Key checked on the expiry cycle; set wins over clear
			if (unlock_trigger && unlock_timer == COUNT_ONE && key_ok &&
				operation_select == OP_UNLOCK) begin
				program_enabled <= 1'b1;
			end else if (wr_main && !reg_wdata[BIT_PROGRAM_ENABLED]) begin
				program_enabled <= 1'b0;
			end
			if (wr_main) begin
				operation_select <= wr_opsel;
				read_enable_ctl <= reg_wdata[BIT_READ_ENABLE];
			end
			// Trigger only counts in unlock mode
			if (wr_main && reg_wdata[BIT_UNLOCK_TRIGGER] && wr_opsel == OP_UNLOCK) begin
				unlock_trigger <= 1'b1;
			end else if (unlock_trigger && unlock_timer == COUNT_ONE) begin
				unlock_trigger <= 1'b0;
			end
			// Start bits stand while the operation runs
			if (launch) begin
				write_start <= start_ok_write;
				read_start <= start_ok_read;
			end else if (op_state == ST_DONE) begin
				write_start <= 1'b0;
				read_start <= 1'b0;
			end
		end
	end

	// Unlock window counter
	always_ff @(posedge clk) begin
		if (rst) begin
			unlock_timer <= COUNT_ZERO;
		end else if (wr_main && reg_wdata[BIT_UNLOCK_TRIGGER] && wr_opsel == OP_UNLOCK) begin
			unlock_timer <= UNLOCK_COUNT;
		end else if (unlock_timer != COUNT_ZERO) begin
			unlock_timer <= unlock_timer - COUNT_ONE;
		end
	end

	// Operation sequencer next state
	always_comb begin
		next_op_state = op_state;
		case (op_state)
			ST_IDLE: begin
				if (launch) begin
					next_op_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (flash_done) begin
					next_op_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_op_state = ST_IDLE;
			end
			default: begin
				next_op_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer state and latched operation
	always_ff @(posedge clk) begin
		if (rst) begin
			op_state <= ST_IDLE;
			active_op <= OP_WRITE;
		end else begin
			op_state <= next_op_state;
			if (launch) begin
				active_op <= wr_opsel;
			end
		end
	end

	// Request pulse to flash and core halt
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_req <= '0;
			core_halt <= 1'b0;
		end else begin
			flash_req.start <= launch;
			if (launch) begin
				flash_req.op <= wr_opsel;
				flash_req.addr <= flash_address_bits;
			end
			core_halt <= (next_op_state != ST_IDLE);
		end
	end

	// Buffer clear control and timer
	always_ff @(posedge clk) begin
		if (rst) begin
			buffer_clear_start <= 1'b0;
			clear_timer <= COUNT_ZERO;
		end else if (wr_clear && reg_wdata[0] && !buffer_clear_start) begin
			buffer_clear_start <= 1'b1;
			clear_timer <= CLEAR_COUNT;
		end else if (buffer_clear_start) begin
			if (clear_timer == COUNT_ONE) begin
				buffer_clear_start <= 1'b0;
			end
			clear_timer <= clear_timer - COUNT_ONE;
		end
	end

	// Buffer clear also follows a finished write
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_clear <= 1'b0;
		end else begin
			buf_clear <= buffer_clear_start ||
				(op_state == ST_DONE && active_op == OP_WRITE);
		end
	end

	// Reset key register and chip reset pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			chip_reset_key <= BYTE_ZERO;
			chip_reset <= 1'b0;
		end else begin
			if (wr_key) begin
				chip_reset_key <= reg_wdata;
			end
			chip_reset <= wr_key && (reg_wdata == CHIP_RESET_KEY);
		end
	end

	// Address register, auto increment on word0 high
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_address_bits <= '0;
		end else if (wr_alow) begin
			flash_address_bits[7:0] <= reg_wdata;
		end else if (wr_ahigh) begin
			flash_address_bits[ADDR_W-1:8] <= reg_wdata[ADDR_W-9:0];
		end else if (wr_w0high) begin
			flash_address_bits <= bump_addr(flash_address_bits);
		end
	end

	// Data words; read data lands in word0
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				word_low[i] <= BYTE_ZERO;
				word_high[i] <= BYTE_ZERO;
			end
		end else if (reg_write && in_data) begin
			if (data_is_high) begin
				word_high[data_idx] <= reg_wdata;
			end else begin
				word_low[data_idx] <= reg_wdata;
			end
		end else if (op_state == ST_RUN && flash_done && active_op == OP_READ) begin
			word_low[0] <= flash_rdata[7:0];
			word_high[0] <= flash_rdata[15:8];
		end
	end

	// Word load into the page buffer, both bytes at once
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_load <= '0;
		end else begin
			buf_load.load <= wr_w0high && program_enabled;
			if (wr_w0high) begin
				buf_load.addr <= flash_address_bits;
				buf_load.data <= {reg_wdata, word_low[0]};
			end
		end
	end

	// Read data mux
	wire [7:0] main_rd = {program_enabled, operation_select, unlock_trigger,
		write_start, read_enable_ctl, read_start};
	wire [7:0] data_rd = data_is_high ? word_high[data_idx] : word_low[data_idx];
	logic [7:0] rd_sel;
	always_comb begin
		if (reg_addr == REG_MAIN_CONTROL) begin
			rd_sel = main_rd;
		end else if (reg_addr == REG_RESET_KEY) begin
			rd_sel = chip_reset_key;
		end else if (reg_addr == REG_BUF_CLEAR) begin
			rd_sel = {7'h00, buffer_clear_start};
		end else if (reg_addr == REG_ADDR_LOW) begin
			rd_sel = flash_address_bits[7:0];
		end else if (reg_addr == REG_ADDR_HIGH) begin
			rd_sel = {2'h0, flash_address_bits[ADDR_W-1:8]};
		end else if (in_data) begin
			rd_sel = data_rd;
		end else if (reg_addr == REG_STATUS) begin
			rd_sel = {6'h00, op_state};
		end else begin
			rd_sel = BYTE_ZERO;
		end
	end

	// Registered read data, valid the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= BYTE_ZERO;
		end else if (reg_read) begin
			reg_rdata <= rd_sel;
		end else begin
			reg_rdata <= BYTE_ZERO;
		end
	end
endmodule // iap_flash_control_regs
`default_nettype wire

// ==== dv/flash_model.sv ====
// Behavioural flash array answering operation requests
`timescale 1ns/1ps
`default_nettype none
module flash_model
	import iap_pkg::*;
#(
	parameter int DELAY = 5 // Busy cycles per operation
)(
	input wire logic clk,
	input wire logic rst,
	input wire flash_req_s flash_req,
	output logic flash_done = 1'b0,
	output logic [15:0] flash_rdata = 16'h0000
);
	int cnt; // Remaining busy cycles
	logic [15:0] word; // Word of the running read
	// Sub-clock taken as stable from reset on
	// One operation at a time; read data valid only with done
	always @(posedge clk) begin
		flash_done <= 1'b0;
		flash_rdata <= ~flash_rdata; // Garbage outside done
		if (rst) begin
			cnt <= 0;
		end else if (flash_req.start && cnt == 0) begin
			cnt <= DELAY;
			word <= {2'h2, flash_req.addr};
		end else if (cnt == 1) begin
			cnt <= 0;
			flash_done <= 1'b1;
			flash_rdata <= word;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule // flash_model
`default_nettype wire

// ==== dv/iap_sva.sv ====
// Port checker for the flash programming registers
`timescale 1ns/1ps
`default_nettype none
module iap_sva
	import iap_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// Flash side
	input wire flash_req_s flash_req,
	input wire logic flash_done,
	input wire logic [15:0] flash_rdata,
	input wire buf_load_s buf_load,
	input wire logic buf_clear,
	// System side
	input wire logic core_halt,
	input wire logic chip_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Write of the chip reset pattern
	sequence key_hit;
		reg_write && reg_addr == REG_RESET_KEY && reg_wdata == CHIP_RESET_KEY;
	endsequence
	// Flash reports done, halt kept one more cycle
	sequence op_end;
		core_halt && flash_done ##1 core_halt;
	endsequence
	a_reset_on_key: assert property (
		key_hit |=> chip_reset) else $error("no chip reset after key");
	a_reset_cause: assert property (
		chip_reset |-> $past(reg_write && reg_addr == REG_RESET_KEY
		&& reg_wdata == CHIP_RESET_KEY)) else $error("stray chip reset");
	a_halt_start: assert property (
		flash_req.start |-> core_halt) else $error("start without halt");
	a_halt_free: assert property (
		op_end |=> !core_halt) else $error("halt held after done");
	a_low_noload: assert property (
		reg_write && reg_addr == REG_WORD0_LOW |=> !buf_load.load) else $error("low byte loaded");
	a_load_word: assert property (
		buf_load.load |-> $past(reg_write && reg_addr == REG_WORD0_HIGH)
		&& buf_load.data[15:8] == $past(reg_wdata)) else $error("bad buffer load");
	a_clear_upper: assert property (
		reg_read && reg_addr == REG_BUF_CLEAR |=> reg_rdata[7:1] == 7'h00) else $error("clear bits");
	a_addr_upper: assert property (
		reg_read && reg_addr == REG_ADDR_HIGH |=> reg_rdata[7:6] == 2'h0) else $error("addr bits");
	a_clear_ends: assert property (
		$rose(buf_clear) |-> ##[1:8] !buf_clear) else $error("clear never ends");
endmodule // iap_sva
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the flash programming registers
`timescale 1ns/1ps
`default_nettype none
module tb
	import iap_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
	logic [15:0] flash_rdata;
	logic flash_done, buf_clear, core_halt, chip_reset;
	flash_req_s flash_req;
	buf_load_s buf_load, ld_last;
	int num_errors = 0, samples_checked = 0, ld_cnt = 0, st_cnt = 0, rs_cnt = 0, n;
	logic [7:0] key [6] = '{KEY_W1_LOW, KEY_W1_HIGH, KEY_W2_LOW, KEY_W2_HIGH, KEY_W3_LOW,
		KEY_W3_HIGH};
	iap_flash_control_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .flash_req(flash_req), .flash_done(flash_done),
		.flash_rdata(flash_rdata), .buf_load(buf_load), .buf_clear(buf_clear),
		.core_halt(core_halt), .chip_reset(chip_reset));
	flash_model #(.DELAY(5)) far (.clk(clk), .rst(rst), .flash_req(flash_req),
		.flash_done(flash_done), .flash_rdata(flash_rdata));
	initial forever #50 clk = ~clk;
	// Count pulses mid-cycle, so counts are settled before the next edge
	always @(negedge clk) begin
		if (buf_load.load) begin
			ld_cnt++;
			ld_last = buf_load;
		end
		if (flash_req.start) st_cnt++;
		if (chip_reset) rs_cnt++;
	end
	task automatic close_out;
		if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One write cycle, then an idle edge so strobes never merge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 rd_val = reg_rdata;
		@(posedge clk);
		chk(what, {8'h00, rd_val}, {8'h00, exp});
	endtask
	// Bounded wait for the core to be released
	task automatic wait_idle;
		for (int i = 0; i < 40 && core_halt !== 1'b0; i++) @(posedge clk);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 15; i++) rchk("reset value", 4'(i), 8'h00);
		for (int i = 5; i < 13; i++) wr(4'(i), 8'(8'hA0 + i));
		for (int i = 5; i < 13; i++) rchk("data byte", 4'(i), 8'(8'hA0 + i));
		chk("loads while locked", 16'(ld_cnt), 16'h0000);
	endtask
	task automatic t_clear;
		wr(REG_BUF_CLEAR, 8'hFF);
		@(negedge clk);
		chk("clear running", {15'h0, buf_clear}, 16'h0001);
		repeat (8) @(posedge clk);
		rchk("clear done", REG_BUF_CLEAR, 8'h00);
	endtask
	task automatic t_read;
		wr(REG_ADDR_LOW, 8'h21);
		wr(REG_ADDR_HIGH, 8'h05);
		wr(REG_MAIN_CONTROL, 8'h33);
		chk("halt on read", {15'h0, core_halt}, 16'h0001);
		chk("req addr", 16'(flash_req.addr), 16'h0521);
		wait_idle;
		rchk("read done", REG_MAIN_CONTROL, 8'h32);
		rchk("read low", REG_WORD0_LOW, 8'h21);
		rchk("read high", REG_WORD0_HIGH, 8'h85);
		n = st_cnt;
		wr(REG_MAIN_CONTROL, 8'h31);
		repeat (3) @(posedge clk);
		chk("read blocked", 16'(st_cnt), 16'(n));
	endtask
	task automatic t_unlock(input logic ok, input logic [7:0] exp);
		wr(REG_MAIN_CONTROL, 8'h68);
		rchk("trigger set", REG_MAIN_CONTROL, 8'h68);
		for (int i = 0; i < 6; i++) wr(4'(REG_WORD1_LOW + i), (ok || i < 5) ? key[i] : 8'hFF);
		repeat (110) @(posedge clk);
		rchk("unlock result", REG_MAIN_CONTROL, exp);
	endtask
	task automatic t_load;
		wr(REG_ADDR_LOW, 8'h3E);
		wr(REG_ADDR_HIGH, 8'h01);
		wr(REG_WORD0_LOW, 8'h34);
		chk("low only stored", 16'(ld_cnt), 16'h0000);
		wr(REG_WORD0_HIGH, 8'h12);
		chk("load count", 16'(ld_cnt), 16'h0001);
		chk("load data", ld_last.data, 16'h1234);
		chk("load addr", 16'(ld_last.addr), 16'h013E);
		rchk("addr step", REG_ADDR_LOW, 8'h3F);
		wr(REG_WORD0_HIGH, 8'h56);
		chk("last addr", 16'(ld_last.addr), 16'h013F);
		rchk("page stop", REG_ADDR_LOW, 8'h3F);
		rchk("addr high", REG_ADDR_HIGH, 8'h01);
	endtask
	task automatic t_ops;
		logic [2:0] ops [2] = '{OP_WRITE, OP_ERASE};
		for (int k = 0; k < 2; k++) begin
			n = st_cnt;
			wr(REG_MAIN_CONTROL, {1'b1, ops[k], 4'h4});
			chk("op code", {13'h0, flash_req.op}, {13'h0, ops[k]});
			chk("halt on op", {15'h0, core_halt}, 16'h0001);
			wait_idle;
			chk("one start", 16'(st_cnt), 16'(n + 1));
			rchk("start cleared", REG_MAIN_CONTROL, {1'b1, ops[k], 4'h0});
		end
	endtask
	task automatic t_disable;
		wr(REG_MAIN_CONTROL, 8'h00);
		wr(REG_MAIN_CONTROL, 8'h80);
		rchk("no soft enable", REG_MAIN_CONTROL, 8'h00);
		n = st_cnt;
		wr(REG_MAIN_CONTROL, 8'h04);
		repeat (3) @(posedge clk);
		chk("write blocked", 16'(st_cnt), 16'(n));
	endtask
	task automatic t_key;
		wr(REG_RESET_KEY, 8'h54);
		rchk("key stored", REG_RESET_KEY, 8'h54);
		chk("no reset", 16'(rs_cnt), 16'h0000);
		wr(REG_RESET_KEY, CHIP_RESET_KEY);
		chk("chip reset", 16'(rs_cnt), 16'h0001);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_clear;
		t_read;
		t_unlock(1'b0, 8'h60);
		t_unlock(1'b1, 8'hE0);
		t_load;
		t_ops;
		t_disable;
		t_key;
		close_out;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		close_out;
	end
endmodule // tb
bind iap_flash_control_regs iap_sva chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .flash_req(flash_req), .flash_done(flash_done),
	.flash_rdata(flash_rdata), .buf_load(buf_load), .buf_clear(buf_clear),
	.core_halt(core_halt), .chip_reset(chip_reset));
`default_nettype wire

// ==== shared/iap_pkg.sv ====
// Shared constants and types for the flash programming register block
package iap_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] REG_MAIN_CONTROL = 4'h0;
	localparam logic [3:0] REG_RESET_KEY = 4'h1;
	localparam logic [3:0] REG_BUF_CLEAR = 4'h2;
	localparam logic [3:0] REG_ADDR_LOW = 4'h3;
	localparam logic [3:0] REG_ADDR_HIGH = 4'h4;
	localparam logic [3:0] REG_WORD0_LOW = 4'h5;
	localparam logic [3:0] REG_WORD0_HIGH = 4'h6;
	localparam logic [3:0] REG_WORD1_LOW = 4'h7;
	localparam logic [3:0] REG_WORD1_HIGH = 4'h8;
	localparam logic [3:0] REG_WORD2_LOW = 4'h9;
	localparam logic [3:0] REG_WORD2_HIGH = 4'hA;
	localparam logic [3:0] REG_WORD3_LOW = 4'hB;
	localparam logic [3:0] REG_WORD3_HIGH = 4'hC;
	localparam logic [3:0] REG_STATUS = 4'hD;
	// Main control bit positions
	localparam int BIT_PROGRAM_ENABLED = 7;
	localparam int BIT_UNLOCK_TRIGGER = 3;
	localparam int BIT_WRITE_START = 2;
	localparam int BIT_READ_ENABLE = 1;
	localparam int BIT_READ_START = 0;
	localparam int OPSEL_LSB = 4;
	// Operation select codes
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_ERASE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_UNLOCK = 3'h6;
	// Reset key and unlock key bytes
	localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
	localparam logic [7:0] KEY_W1_LOW = 8'h00;
	localparam logic [7:0] KEY_W1_HIGH = 8'h04;
	localparam logic [7:0] KEY_W2_LOW = 8'h0D;
	localparam logic [7:0] KEY_W2_HIGH = 8'h09;
	localparam logic [7:0] KEY_W3_LOW = 8'hC3;
	localparam logic [7:0] KEY_W3_HIGH = 8'h40;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Address sizing: up to bit 13, 64-word pages
	localparam int ADDR_W = 14;
	localparam int PAGE_BITS = 6;
	localparam logic [PAGE_BITS-1:0] PAGE_LAST = 6'h3F;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
	// Timing: unlock window and clear duration
	localparam int CLK_HZ = 10_000_000;
	localparam int UNLOCK_WINDOW_US = 10;
	localparam int UNLOCK_CYCLES = (UNLOCK_WINDOW_US * (CLK_HZ / 1_000_000));
	localparam logic [7:0] UNLOCK_COUNT = 8'(UNLOCK_CYCLES);
	localparam logic [7:0] CLEAR_COUNT = 8'h04;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	// Operation states, Gray coded along idle-run-done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b11
	} op_state_e;
	// Request to the flash array
	typedef struct packed {
		logic start;
		logic [2:0] op;
		logic [ADDR_W-1:0] addr;
	} flash_req_s;
	// Write buffer load strobe with data
	typedef struct packed {
		logic load;
		logic [ADDR_W-1:0] addr;
		logic [15:0] data;
	} buf_load_s;
endpackage
